/* edid_ddc_status_config.sv */
// How it works
// - Status bit 7 shows source supply present
// - Status bit 6 shows pending receiver interrupt
// - Status bit 2 shows configuration finished first
// - Status bit 4 only after configuration done
// - Status bit 3 shows remote table loaded
// - Status bit 1 shows last-128-byte checksum pass
// - Status bit 0 shows first-256-byte checksum pass
// - Answer at address field bits 7:1, default 0x50
// - Write protect bit 0 blocks channel writes
// - Data hold time in 40 ns steps
// - Hold time qualifies start and stop detection
// - Glitch filter rejects pulses, 5 ns steps
// - Data output delay 240 ns plus 40 ns steps
// - Strapped disable bit blocks all channel access
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "edid_ddc_params.svh"
module edid_ddc_status_config
  import edid_ddc_pkg::*;
#(
  parameter int TABLE_DEPTH = 256
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [8:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_irq,
  input wire logic i_source_supply_pin,
  input wire logic i_mode_strap,
  input wire logic i_receiver_irq,
  input wire logic i_config_done,
  input wire logic i_init_done,
  input wire logic i_remote_loaded,
  input wire logic i_config_checksum_ok,
  input wire logic i_table_checksum_ok,
  input wire logic i_load_valid,
  input wire logic [7:0] i_load_addr,
  input wire logic [7:0] i_load_data,
  input wire logic i_display_channel_clock,
  input wire logic i_display_channel_data,
  output logic o_display_channel_data,
  output logic o_display_channel_data_oe_n,
  output logic o_table_access_disable
);

  logic [7:0] bridge_status;
  logic [7:0] table_slave_address;
  logic [7:0] table_bus_timing_config;
  logic [7:0] table_output_delay_config;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic served;
  logic strap_taken;
  logic [7:0] table_mem [TABLE_DEPTH];
  logic [1:0] line_s1;
  logic [1:0] line_s2;
  logic [1:0] line_filt;
  logic [7:0] line_cnt [2];
  logic [7:0] scl_high_cnt;
  logic [3:0] prev_events;
  ddc_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx_byte;
  logic [7:0] ptr;
  logic first_byte;
  logic rw;
  logic host_nack;
  logic pend_val;
  logic [4:0] dly_cnt;
  logic sda_drive_low;

  // Bus decode
  wire req = i_read | i_write;
  wire read_fire = i_read & served;
  wire write_fire = i_write & served;
  wire [6:0] idx = i_address[8:2];
  wire sel_status = (idx == `IDX_BRIDGE_STATUS);
  wire sel_addr = (idx == `IDX_SLAVE_ADDRESS);
  wire sel_timing = (idx == `IDX_BUS_TIMING);
  wire sel_delay = (idx == `IDX_OUTPUT_DELAY);
  wire sel_irq = (idx == `IDX_IRQ_STATUS);
  wire sel_mask = (idx == `IDX_IRQ_MASK);
  wire [7:0] read_mux = sel_status ? bridge_status :
    sel_addr ? table_slave_address :
    sel_timing ? table_bus_timing_config :
    sel_delay ? table_output_delay_config :
    sel_irq ? {4'h0, irq_status} :
    sel_mask ? {4'h0, irq_mask} : 8'h00;
  assign o_waitrequest = req & ~served;

  // Field decode and derived cycle counts
  wire table_write_protect = table_slave_address[`BIT_WRITE_PROTECT];
  wire [2:0] data_hold_qualifier = table_bus_timing_config[6:4];
  wire [3:0] glitch_filter_depth = table_bus_timing_config[3:0];
  wire [1:0] data_output_delay = table_output_delay_config[1:0];
  wire [7:0] hold_cycles = 8'({5'h00, data_hold_qualifier} * `HOLD_UNIT_NS / `CLK_PERIOD_NS);
  wire [7:0] filt_cycles = 8'({4'h0, glitch_filter_depth} * `FILTER_UNIT_NS / `CLK_PERIOD_NS + 1);
  wire [4:0] out_dly_cycles = 5'((`OUT_DELAY_BASE_NS + {3'h0, data_output_delay}
    * `OUT_DELAY_STEP_NS) / `CLK_PERIOD_NS);

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      served <= 1'b0;
      o_readdata <= 32'h0000_0000;
    end
    else
    begin
      served <= req & ~served;
      if (req & ~served)
        o_readdata <= {24'h00_0000, read_mux};
    end
  end

  // Source supply pin through two flops
  logic supply_s1;
  logic supply_s2;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      supply_s1 <= 1'b0;
      supply_s2 <= 1'b0;
    end
    else
    begin
      supply_s1 <= i_source_supply_pin;
      supply_s2 <= supply_s1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      bridge_status <= `RST_BRIDGE_STATUS;
    else
    begin
      bridge_status[`BIT_SUPPLY] <= supply_s2;
      bridge_status[`BIT_RX_IRQ] <= i_receiver_irq;
      // Reserved bit always reads zero
      bridge_status[5] <= 1'b0;
      // init done gated by config done
      bridge_status[`BIT_INIT_DONE] <= i_init_done & i_config_done;
      bridge_status[`BIT_REMOTE_LOADED] <= i_remote_loaded;
      bridge_status[`BIT_CONFIG_DONE] <= i_config_done;
      bridge_status[`BIT_CONFIG_CKSUM] <= i_config_checksum_ok;
      bridge_status[`BIT_TABLE_CKSUM] <= i_table_checksum_ok;
    end
  end

  // Writable configuration; status ignores writes
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      table_slave_address <= `RST_SLAVE_ADDRESS;
      table_bus_timing_config <= `RST_BUS_TIMING;
      table_output_delay_config <= `RST_OUTPUT_DELAY;
      irq_mask <= 4'(`RST_IRQ_MASK);
    end
    else if (write_fire)
    begin
      if (sel_addr)
        table_slave_address <= i_writedata[7:0];
      if (sel_timing)
        table_bus_timing_config <= {1'b0, i_writedata[6:0]};
      if (sel_delay)
        table_output_delay_config <= {6'h00, i_writedata[1:0]};
      if (sel_mask)
        irq_mask <= i_writedata[3:0];
    end
  end

  // strap caught once, after two sync flops
  // Strap is static, but it still enters from a pin, so it is synchronised first
  logic [1:0] strap_sync;
  logic [1:0] strap_age;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      strap_sync <= 2'h0;
      strap_age <= 2'h0;
      strap_taken <= 1'b0;
      o_table_access_disable <= 1'b0;
    end
    else
    begin
      strap_sync <= {strap_sync[0], i_mode_strap};
      strap_age <= {strap_age[0], 1'b1};
      if (strap_age[1] & ~strap_taken)
      begin
        strap_taken <= 1'b1;
        o_table_access_disable <= strap_sync[1];
      end
    end
  end

  // Interrupt events on rising edges; set wins over read clear
  wire [3:0] cur_events = {i_receiver_irq, i_remote_loaded, i_init_done & i_config_done,
    i_config_done};
  wire [3:0] new_events = cur_events & ~prev_events;
  wire irq_clear = read_fire & sel_irq;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prev_events <= 4'h0;
      irq_status <= 4'h0;
    end
    else
    begin
      prev_events <= cur_events;
      irq_status <= (irq_clear ? 4'h0 : irq_status) | new_events;
    end
  end
  assign o_irq = |(irq_status & irq_mask);

  // Channel lines: two-flop sync then glitch filter
  wire [1:0] line_raw = {i_display_channel_data, i_display_channel_clock};
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_line
      always_ff @(posedge i_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          line_s1[g] <= 1'b1;
          line_s2[g] <= 1'b1;
          line_filt[g] <= 1'b1;
          line_cnt[g] <= 8'h00;
        end
        else
        begin
          line_s1[g] <= line_raw[g];
          line_s2[g] <= line_s1[g];
          if (line_s2[g] == line_filt[g])
            line_cnt[g] <= 8'h00;
          else if (line_cnt[g] == filt_cycles)
          begin
            line_filt[g] <= line_s2[g];
            line_cnt[g] <= 8'h00;
          end
          else
            line_cnt[g] <= line_cnt[g] + 8'h01;
        end
      end
    end
  endgenerate

  logic scl_q;
  logic sda_q;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_high_cnt <= 8'h00;
    end
    else
    begin
      scl_q <= line_filt[0];
      sda_q <= line_filt[1];
      if (!line_filt[0])
        scl_high_cnt <= 8'h00;
      else if (scl_high_cnt != 8'hFF)
        scl_high_cnt <= scl_high_cnt + 8'h01;
    end
  end

  wire scl_rise = line_filt[0] & ~scl_q;
  wire scl_fall = ~line_filt[0] & scl_q;
  wire hold_met = (scl_high_cnt >= hold_cycles);
  wire start_det = line_filt[0] & scl_q & sda_q & ~line_filt[1] & hold_met;
  wire stop_det = line_filt[0] & scl_q & ~sda_q & line_filt[1] & hold_met;
  wire addr_hit = (shift[7:1] == table_slave_address[7:1]);
  wire addr_ok = addr_hit & ~o_table_access_disable;
  wire byte_done = (bit_cnt == 4'd8);
  wire ddc_we = scl_fall & (state == ST_RX) & byte_done & ~first_byte & ~table_write_protect;
  wire [7:0] ptr_next = ptr + 8'h01;
  logic arm;
  logic arm_val;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx_byte <= 8'h00;
      ptr <= 8'h00;
      first_byte <= 1'b0;
      rw <= 1'b0;
      host_nack <= 1'b0;
    end
    else if (start_det)
    begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
    end
    else if (stop_det)
      state <= ST_IDLE;
    else if (scl_rise)
    begin
      shift <= {shift[6:0], line_filt[1]};
      bit_cnt <= bit_cnt + 4'h1;
      if (state == ST_TX_ACK)
        host_nack <= line_filt[1];
    end
    else if (scl_fall)
    begin
      case (state)
        ST_ADDR:
          if (byte_done)
          begin
            state <= addr_ok ? ST_ADDR_ACK : ST_IDLE;
            rw <= shift[0];
          end
        ST_ADDR_ACK:
        begin
          state <= rw ? ST_TX : ST_RX;
          first_byte <= 1'b1;
          tx_byte <= table_mem[ptr];
          bit_cnt <= 4'h0;
        end
        ST_RX:
          if (byte_done)
          begin
            state <= ST_RX_ACK;
            first_byte <= 1'b0;
            ptr <= first_byte ? shift : ptr_next;
          end
        ST_RX_ACK:
        begin
          state <= ST_RX;
          bit_cnt <= 4'h0;
        end
        ST_TX:
          if (byte_done)
            state <= ST_TX_ACK;
        ST_TX_ACK:
          if (host_nack)
            state <= ST_IDLE;
          else
          begin
            state <= ST_TX;
            ptr <= ptr_next;
            tx_byte <= table_mem[ptr_next];
            bit_cnt <= 4'h0;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Whether to pull the data line low after this falling edge
  always_comb
  begin
    arm = scl_fall;
    arm_val = 1'b0;
    case (state)
      ST_ADDR: arm_val = byte_done & addr_ok;
      ST_ADDR_ACK: arm_val = rw & ~table_mem[ptr][7];
      ST_RX: arm_val = byte_done;
      ST_TX: arm_val = ~byte_done & ~tx_byte[3'(7 - bit_cnt[2:0])];
      ST_TX_ACK: arm_val = ~host_nack & ~table_mem[ptr_next][7];
      default: arm_val = 1'b0;
    endcase
  end

  // delayed data output after clock fall
  wire apply = (dly_cnt == 5'd1);
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      dly_cnt <= 5'd0;
      pend_val <= 1'b0;
      sda_drive_low <= 1'b0;
    end
    else if (start_det | stop_det)
    begin
      dly_cnt <= 5'd0;
      sda_drive_low <= 1'b0;
    end
    else if (arm)
    begin
      dly_cnt <= out_dly_cycles;
      pend_val <= arm_val;
    end
    else if (dly_cnt != 5'd0)
    begin
      dly_cnt <= dly_cnt - 5'd1;
      if (apply)
        sda_drive_low <= pend_val;
    end
  end
  // Open drain: only ever pulls low
  assign o_display_channel_data = 1'b0;
  assign o_display_channel_data_oe_n = ~sda_drive_low;

  // Remote load wins a same-cycle collision with a channel write
  always_ff @(posedge i_clk)
  begin
    if (i_load_valid)
      table_mem[i_load_addr] <= i_load_data;
    else if (ddc_we)
      table_mem[ptr] <= shift;
  end

  property p_supply;
    @(posedge i_clk) disable iff (!i_reset_n)
    bridge_status[`BIT_SUPPLY] == $past(supply_s2);
  endproperty
  a_supply: assert property (p_supply) else $error("supply bit wrong");
  property p_rx_irq;
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(i_receiver_irq) |=> bridge_status[`BIT_RX_IRQ] ##1 irq_status[`IRQB_RX_IRQ];
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receiver irq not shown");
  property p_init_order;
    @(posedge i_clk) disable iff (!i_reset_n)
    bridge_status[`BIT_INIT_DONE] |-> bridge_status[`BIT_CONFIG_DONE];
  endproperty
  a_init_order: assert property (p_init_order) else $error("init before config");
  property p_addr_match;
    @(posedge i_clk) disable iff (!i_reset_n)
    scl_fall && state == ST_ADDR && byte_done && !addr_hit |=> state == ST_IDLE;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("foreign address taken");
  property p_protect;
    @(posedge i_clk) disable iff (!i_reset_n)
    scl_fall && state == ST_RX && byte_done && !first_byte && table_write_protect &&
      !i_load_valid |=> table_mem[$past(ptr)] == $past(table_mem[ptr]);
  endproperty
  a_protect: assert property (p_protect) else $error("write while protected");
  property p_disable;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_table_access_disable && state == ST_ADDR |=> state != ST_ADDR_ACK;
  endproperty
  a_disable: assert property (p_disable) else $error("access while disabled");
  property p_out_delay;
    @(posedge i_clk) disable iff (!i_reset_n)
    arm && data_output_delay == 2'b00 && !start_det && !stop_det |->
      ##12 (apply && sda_drive_low == $past(sda_drive_low)) ##1 sda_drive_low == pend_val;
  endproperty
  a_out_delay: assert property (p_out_delay) else $error("output delay wrong");
  property p_filter;
    @(posedge i_clk) disable iff (!i_reset_n)
    $changed(line_filt[0]) |-> $past(line_cnt[0]) == $past(filt_cycles);
  endproperty
  a_filter: assert property (p_filter) else $error("glitch passed filter");
  property p_start_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
    start_det |-> scl_high_cnt >= hold_cycles ##1 state == ST_ADDR;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start not qualified");
  property p_status_ro;
    @(posedge i_clk) disable iff (!i_reset_n)
    write_fire && sel_status |=> bridge_status[5] == 1'b0;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status took a write");

  c_ddc_write: cover property (@(posedge i_clk) ddc_we);
  c_ddc_read: cover property (@(posedge i_clk) state == ST_TX_ACK && scl_fall);
  c_irq: cover property (@(posedge i_clk) o_irq);

endmodule // edid_ddc_status_config

/* edid_ddc_params.svh */
`ifndef EDID_DDC_PARAMS_SVH
`define EDID_DDC_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_BRIDGE_STATUS 7'h50
`define IDX_SLAVE_ADDRESS 7'h51
`define IDX_BUS_TIMING 7'h52
`define IDX_OUTPUT_DELAY 7'h53
`define IDX_IRQ_STATUS 7'h58
`define IDX_IRQ_MASK 7'h59

// Reset values
`define RST_BRIDGE_STATUS 8'h03
`define RST_SLAVE_ADDRESS 8'hA0
`define RST_BUS_TIMING 8'h1E
`define RST_OUTPUT_DELAY 8'h00
`define RST_IRQ_MASK 8'h00

// Field positions
`define BIT_SUPPLY 7
`define BIT_RX_IRQ 6
`define BIT_INIT_DONE 4
`define BIT_REMOTE_LOADED 3
`define BIT_CONFIG_DONE 2
`define BIT_CONFIG_CKSUM 1
`define BIT_TABLE_CKSUM 0
`define BIT_WRITE_PROTECT 0

// Interrupt status layout
`define IRQB_CONFIG_DONE 0
`define IRQB_INIT_DONE 1
`define IRQB_REMOTE_LOADED 2
`define IRQB_RX_IRQ 3

// Timing
`define CLK_PERIOD_NS 20
`define HOLD_UNIT_NS 40
`define FILTER_UNIT_NS 5
`define OUT_DELAY_BASE_NS 240
`define OUT_DELAY_STEP_NS 40

`endif

/* edid_ddc_pkg.sv */
package edid_ddc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_RX = 3'b010,
    ST_RX_ACK = 3'b110,
    ST_TX = 3'b111,
    ST_TX_ACK = 3'b101
  } ddc_state_t;
endpackage

/* ddc_host_model.sv */
`timescale 1ns/1ns
module ddc_host_model
#(
  parameter int QUARTER = 16
)
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe_n
);
  // Slow clock: the device answers up to 520 ns late (8 cycles plus 360 ns delay), so low phase is 640 ns
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end
  task automatic wait_q();
    repeat (QUARTER) @(posedge i_clk);
  endtask
  task automatic bit_io(input logic b, output logic got);
    o_sda_oe_n <= b;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    got = i_sda;
    wait_q();
    o_scl <= 1'b0;
    wait_q();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ack_out, output logic [7:0] q,
                         output logic ack_in);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_out, ack_in);
  endtask
  task automatic send_address(input logic [6:0] a, input logic rd, output logic ack_in);
    logic [7:0] q;
    byte_io({a, rd}, 1'b1, q, ack_in);
  endtask
  task automatic start_cond();
    o_sda_oe_n <= 1'b1;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    o_sda_oe_n <= 1'b0;
    wait_q();
    o_scl <= 1'b0;
    wait_q();
  endtask
  // Clock left high after stop, so the line stands still between frames
  task automatic stop_cond();
    o_sda_oe_n <= 1'b0;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    o_sda_oe_n <= 1'b1;
    wait_q();
  endtask
endmodule // ddc_host_model

/* edid_ddc_status_config_tb.sv */
`timescale 1ns/1ns
`include "edid_ddc_params.svh"
module edid_ddc_status_config_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] addr = 9'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq, irq, sdo, oe_n, dis, scl, host_oe_n;
  logic [6:0] ev = 7'h03;
  logic strap = 1'b0;
  logic lv = 1'b0;
  logic [7:0] la = 8'h0;
  logic [7:0] ld = 8'h0;
  wire sda;
  int seed = 32'h2609;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int fall_at = 0;
  int lag = 0;
  logic scl_q = 1'b1;
  logic oe_q = 1'b1;
  logic [31:0] q;
  logic [7:0] b, r;
  logic [2:0] ak;
  logic a1;
  int imap[4] = '{2, 4, 3, 5};

  always #10 clk = ~clk;
  // Open-drain data line with pull-up
  assign sda = host_oe_n & (oe_n | sdo);

  edid_ddc_status_config edid_ddc_status_config_i (
    .i_clk(clk), .i_reset_n(rst_n), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(wreq), .o_irq(irq),
    .i_source_supply_pin(ev[6]), .i_mode_strap(strap), .i_receiver_irq(ev[5]),
    .i_config_done(ev[2]), .i_init_done(ev[4]), .i_remote_loaded(ev[3]),
    .i_config_checksum_ok(ev[1]), .i_table_checksum_ok(ev[0]), .i_load_valid(lv),
    .i_load_addr(la), .i_load_data(ld), .i_display_channel_clock(scl),
    .i_display_channel_data(sda), .o_display_channel_data(sdo),
    .o_display_channel_data_oe_n(oe_n), .o_table_access_disable(dis));

  ddc_host_model ddc_host_model_i (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_oe_n(host_oe_n));

  // Cycles from a clock fall on the pin to the device pulling data low
  always @(posedge clk)
  begin
    cyc++;
    if (scl_q === 1'b1 && scl === 1'b0) fall_at = cyc;
    if (oe_q === 1'b1 && oe_n === 1'b0) lag = cyc - fall_at;
    scl_q = scl;
    oe_q = oe_n;
  end

  function automatic logic [7:0] sts_exp(input logic [6:0] e);
    return {e[6], e[5], 1'b0, e[4] & e[2], e[3:0]};
  endfunction

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d,
                     output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    rd <= ~w;
    wr <= w;
    // Waitrequest sampled at the rising edge; data taken and request dropped there
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    rq = rdata;
    if (n >= 50) miscompares++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] e);
    logic [31:0] v;
    bus(1'b0, idx, 8'h00, v);
    check(v, {24'h0, e});
  endtask

  task automatic irq_chk(input logic e);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, e});
  endtask

  task automatic ch_wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
                       output logic [2:0] k);
    logic [7:0] x;
    ddc_host_model_i.start_cond();
    ddc_host_model_i.send_address(a, 1'b0, k[2]);
    ddc_host_model_i.byte_io(off, 1'b1, x, k[1]);
    ddc_host_model_i.byte_io(d, 1'b1, x, k[0]);
    ddc_host_model_i.stop_cond();
  endtask

  task automatic ch_rd(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d,
                       output logic k);
    logic x;
    ddc_host_model_i.start_cond();
    ddc_host_model_i.send_address(a, 1'b0, k);
    ddc_host_model_i.byte_io(off, 1'b1, d, x);
    ddc_host_model_i.start_cond();
    ddc_host_model_i.send_address(a, 1'b1, x);
    ddc_host_model_i.byte_io(8'hFF, 1'b1, d, x);
    ddc_host_model_i.stop_cond();
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({31'h0, dis}, 32'h0);
    rd_chk(7'h50, 8'h03);
    rd_chk(7'h51, 8'hA0);
    rd_chk(7'h52, 8'h1E);
    rd_chk(7'h53, 8'h00);
    rd_chk(7'h59, 8'h00);
    rd_chk(7'h60, 8'h00);
    bus(1'b1, 7'h50, 8'hFF, q);
    rd_chk(7'h50, 8'h03);
    for (int i = 0; i < 12; i++)
    begin
      ev <= (i == 0) ? 7'h10 : (i == 1) ? 7'h14 : 7'($random(seed));
      repeat (4) @(posedge clk);
      rd_chk(7'h50, sts_exp(ev));
      rd_chk(7'h50, sts_exp(ev));
    end
    for (int i = 0; i < 4; i++)
    begin
      ev <= (i == 1) ? 7'h04 : 7'h00;
      repeat (4) @(posedge clk);
      bus(1'b0, 7'h58, 8'h00, q);
      ev <= ev | (7'h01 << imap[i]);
      repeat (4) @(posedge clk);
      irq_chk(1'b0);
      bus(1'b1, 7'h59, 8'h01 << i, q);
      irq_chk(1'b1);
      rd_chk(7'h58, 8'h01 << i);
      irq_chk(1'b0);
      rd_chk(7'h58, 8'h00);
      bus(1'b1, 7'h59, 8'h00, q);
    end
    bus(1'b1, 7'h52, 8'h37, q);
    rd_chk(7'h52, 8'h37);
    bus(1'b1, 7'h52, 8'h1E, q);
    for (int d = 0; d < 4; d++)
    begin
      bus(1'b1, 7'h53, 8'(d), q);
      rd_chk(7'h53, 8'(d));
      b = 8'($random(seed));
      ch_wr(7'h50, 8'(d), b, ak);
      check({29'h0, ak}, 32'h0);
      // Eight cycles of sync, filter and arm latency at the default filter depth
      check(32'(lag), 32'(8 + (`OUT_DELAY_BASE_NS + `OUT_DELAY_STEP_NS * d) / `CLK_PERIOD_NS));
      ch_rd(7'h50, 8'(d), r, a1);
      check({24'h0, r}, {24'h0, b});
    end
    la <= 8'h40;
    ld <= 8'h5A;
    lv <= 1'b1;
    @(posedge clk);
    lv <= 1'b0;
    bus(1'b1, 7'h51, 8'hA1, q);
    rd_chk(7'h51, 8'hA1);
    ch_wr(7'h50, 8'h40, 8'hC3, ak);
    check({29'h0, ak}, 32'h0);
    ch_rd(7'h50, 8'h40, r, a1);
    check({24'h0, r}, 32'h5A);
    bus(1'b1, 7'h51, 8'h6E, q);
    ch_wr(7'h50, 8'h41, 8'h11, ak);
    check({31'h0, ak[2]}, 32'h1);
    ch_rd(7'h37, 8'h40, r, a1);
    check({23'h0, a1, r}, 32'h5A);
    strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({31'h0, dis}, 32'h1);
    ch_rd(7'h50, 8'h40, r, a1);
    check({31'h0, a1}, 32'h1);
    close_out();
  end
endmodule // edid_ddc_status_config_tb
